/* src/rpscn_pkg.sv */
// How it works
// - Port reads of pins marked analog return zero whatever the pin voltage.
// - Analog pin set as output feeds its own driven level to the converter.
// - Any enabled change-notify input changing state raises a request, 21 inputs.
// - Each change-notify input has its own enable bit.
// - Each change-notify input has its own weak pull-up control bit.
// - Up to 16 remappable pins, each known by its number.
// - Each peripheral input has a 5-bit field choosing its feeding pin.
// - Fourteen selectable peripheral inputs: irqs, timer clocks, captures, fault, UART, SPI.
// - Each pin has a 5-bit output field; zero leaves default port logic.
// - Codes 00011, 00100, 00111 route UART transmit, UART RTS, SPI data out.
// - Codes 01000 and 01001 route SPI clock out and SPI select out.
// - Codes 10010 and 10011 route compare outputs one and two.
// - While locked, map writes complete but leave contents unchanged.
// - Lock changes only after keys 0x46 then 0x57 to oscillator control.
// - Lock holds until rewritten; it is not re-armed after one write.
// - Shadow copies check the map; any difference raises a mismatch reset.
// - With one-way set, a set lock cannot be cleared again until reset.
// - One-way defaults set; cleared it allows unlimited unlock sessions.
// - Direction bit one means input; all pins reset as inputs.
// - Input code 11111 ties to ground, 00000 to 01111 pick a pin; reset all ones.
package rpscn_pkg;
  localparam int          NUM_RPIN      = 16;
  localparam int          NUM_CN        = 21;
  localparam int          NUM_CN_LOW    = 16;
  localparam int          SEL_W         = 5;
  localparam int          NUM_PIN_IN    = 14;
  localparam logic [4:0]  SEL_GROUND    = 5'h1F;
  localparam logic [4:0]  SEL_NULL      = 5'h00;
  localparam logic [4:0]  OUT_UART_TX   = 5'h03;
  localparam logic [4:0]  OUT_UART_RTS  = 5'h04;
  localparam logic [4:0]  OUT_SPI_DATA  = 5'h07;
  localparam logic [4:0]  OUT_SPI_CLK   = 5'h08;
  localparam logic [4:0]  OUT_SPI_SEL   = 5'h09;
  localparam logic [4:0]  OUT_CMP_ONE   = 5'h12;
  localparam logic [4:0]  OUT_CMP_TWO   = 5'h13;
  localparam logic [7:0]  UNLOCK_KEY_A  = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY_B  = 8'h57;
  localparam int          LOCK_BIT      = 6;
  localparam logic        LOCK_RESET    = 1'h0;
  localparam logic        DIR_INPUT     = 1'h1;
  localparam int          IDX_EXT_IRQ_ONE      = 0;
  localparam int          IDX_EXT_IRQ_TWO      = 1;
  localparam int          IDX_TIMER_B_CLOCK    = 2;
  localparam int          IDX_TIMER_C_CLOCK    = 3;
  localparam int          IDX_CAPTURE_ONE      = 4;
  localparam int          IDX_CAPTURE_TWO      = 5;
  localparam int          IDX_CAPTURE_SEVEN    = 6;
  localparam int          IDX_CAPTURE_EIGHT    = 7;
  localparam int          IDX_COMPARE_FAULT    = 8;
  localparam int          IDX_UART_RECEIVE     = 9;
  localparam int          IDX_UART_CTS         = 10;
  localparam int          IDX_SPI_DATA_IN      = 11;
  localparam int          IDX_SPI_CLOCK_IN     = 12;
  localparam int          IDX_SPI_SELECT_IN    = 13;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_SECOND} rpscn_key_t;
endpackage

/* src/rpscn_lock_if.sv */
`timescale 1ns/1ps
interface rpscn_lock_if;
  logic       oscWrEn;
  logic [7:0] oscWrData;
  logic       otherWrEn;
  logic       lock;
  modport ctrl   (output oscWrEn, output oscWrData, output otherWrEn, input lock);
  modport keeper (input oscWrEn, input oscWrData, input otherWrEn, output lock);
endinterface

/* src/rpscn_sync.sv */
`timescale 1ns/1ps
module rpscn_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_reg;
  logic [WIDTH-1:0] stageOne_next;
  logic [WIDTH-1:0] stageTwo_reg;
  logic [WIDTH-1:0] stageTwo_next;

  always_comb
  begin
    stageOne_next = asyncIn;
    stageTwo_next = stageOne_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stageOne_reg <= '0;
      stageTwo_reg <= '0;
    end
    else
    begin
      stageOne_reg <= stageOne_next;
      stageTwo_reg <= stageTwo_next;
    end
  end

  assign syncOut = stageTwo_reg;
endmodule

/* src/rpscn_unlock.sv */
`timescale 1ns/1ps
module rpscn_unlock (
  input  wire logic    sys_clk,
  input  wire logic    reset,
  input  wire logic    oneWayLockCfg,
  rpscn_lock_if.keeper lk
);
  rpscn_pkg::rpscn_key_t keyState_reg;
  rpscn_pkg::rpscn_key_t keyState_next;
  logic                  lock_reg;
  logic                  lock_next;
  logic                  oneWay_reg;
  logic                  oneWay_next;
  logic                  strapTaken_reg;
  logic                  strapTaken_next;

  always_comb
  begin
    keyState_next   = keyState_reg;
    lock_next       = lock_reg;
    strapTaken_next = 1'b1;
    oneWay_next     = strapTaken_reg ? oneWay_reg : oneWayLockCfg;
    if (lk.otherWrEn)
      keyState_next = rpscn_pkg::KEY_IDLE;
    else if (lk.oscWrEn)
    begin
      case (keyState_reg)
        rpscn_pkg::KEY_IDLE:
          keyState_next = (lk.oscWrData == rpscn_pkg::UNLOCK_KEY_A) ? rpscn_pkg::KEY_FIRST : rpscn_pkg::KEY_IDLE;
        rpscn_pkg::KEY_FIRST:
          keyState_next = (lk.oscWrData == rpscn_pkg::UNLOCK_KEY_B) ? rpscn_pkg::KEY_SECOND : rpscn_pkg::KEY_IDLE;
        rpscn_pkg::KEY_SECOND:
        begin
          keyState_next = rpscn_pkg::KEY_IDLE;
          if (!(oneWay_reg && lock_reg))
            lock_next = lk.oscWrData[rpscn_pkg::LOCK_BIT];
        end
        default:
          keyState_next = rpscn_pkg::KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      keyState_reg   <= rpscn_pkg::KEY_IDLE;
      lock_reg       <= rpscn_pkg::LOCK_RESET;
      oneWay_reg     <= 1'b1;
      strapTaken_reg <= 1'b0;
    end
    else
    begin
      keyState_reg   <= keyState_next;
      lock_reg       <= lock_next;
      oneWay_reg     <= oneWay_next;
      strapTaken_reg <= strapTaken_next;
    end
  end

  assign lk.lock = lock_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence keysGiven;
    lk.oscWrEn && !lk.otherWrEn && lk.oscWrData == rpscn_pkg::UNLOCK_KEY_A
    ##1 lk.oscWrEn && !lk.otherWrEn && lk.oscWrData == rpscn_pkg::UNLOCK_KEY_B;
  endsequence

  keys_open_lock_a: assert property (
    keyState_reg == rpscn_pkg::KEY_IDLE ##0 keysGiven ##1 (lk.oscWrEn && !lk.otherWrEn && !(oneWay_reg && lock_reg))
    |=> lock_reg == $past(lk.oscWrData[rpscn_pkg::LOCK_BIT]))
    else $error("Lock did not follow the write after both keys.");

  lock_holds_a: assert property (
    keyState_reg != rpscn_pkg::KEY_SECOND |=> $stable(lock_reg))
    else $error("Lock changed without a completed key sequence.");

  one_way_a: assert property (
    oneWay_reg && lock_reg |=> lock_reg)
    else $error("Lock cleared while one-way lock was in force.");

  abort_keys_a: assert property (
    lk.otherWrEn |=> keyState_reg == rpscn_pkg::KEY_IDLE)
    else $error("Key sequence survived an intervening write.");
endmodule

/* src/rpscn_top.sv */
`timescale 1ns/1ps
module rpscn_top #(
  parameter int NUM_RPIN = rpscn_pkg::NUM_RPIN,
  parameter int NUM_CN   = rpscn_pkg::NUM_CN
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic [NUM_RPIN-1:0]  padIn,
  output logic      [NUM_RPIN-1:0]  padOut,
  output logic      [NUM_RPIN-1:0]  padOutEn,
  input  wire logic [NUM_RPIN-1:0]  portLatch,
  input  wire logic                 dirWrEn,
  input  wire logic [NUM_RPIN-1:0]  dirWrData,
  output logic      [NUM_RPIN-1:0]  pinDirection,
  input  wire logic [NUM_RPIN-1:0]  analogPinConfig,
  output logic      [NUM_RPIN-1:0]  portRead,
  output logic      [NUM_RPIN-1:0]  converterIn,
  input  wire logic [NUM_CN-1:0]    changeNotifyIn,
  input  wire logic [15:0]          notifyEnableLow,
  input  wire logic [NUM_CN-17:0]   notifyEnableHigh,
  input  wire logic [15:0]          pullupEnableLow,
  input  wire logic [NUM_CN-17:0]   pullupEnableHigh,
  output logic      [NUM_CN-1:0]    pullupOn,
  output logic                      changeNotifyReq,
  input  wire logic                 mapWrEn,
  input  wire logic                 mapWrOutput,
  input  wire logic [4:0]           mapWrIndex,
  input  wire logic [4:0]           mapWrData,
  input  wire logic                 mapRdOutput,
  input  wire logic [4:0]           mapRdIndex,
  output logic      [4:0]           mapRdData,
  input  wire logic                 oscWrEn,
  input  wire logic [7:0]           oscWrData,
  input  wire logic                 otherWrEn,
  input  wire logic                 oneWayLockCfg,
  output logic                      mapLock,
  output logic                      mismatchReset,
  input  wire logic                 uartTransmitOut,
  input  wire logic                 uartRtsOut,
  input  wire logic                 spiDataOut,
  input  wire logic                 spiClockOut,
  input  wire logic                 spiSelectOut,
  input  wire logic                 compareOutOne,
  input  wire logic                 compareOutTwo,
  output logic [rpscn_pkg::NUM_PIN_IN-1:0] peripheralIn
);
  localparam int NI = rpscn_pkg::NUM_PIN_IN;

  if (NUM_RPIN < 1 || NUM_RPIN > rpscn_pkg::NUM_RPIN || NUM_CN != rpscn_pkg::NUM_CN)
  begin
    $error("Unsupported pin or notify count.");
  end

  logic [NUM_RPIN-1:0] padSync;
  logic [NUM_CN-1:0]   cnSync;

  rpscn_sync #(.WIDTH(NUM_RPIN)) padSyncer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn (padIn),
    .syncOut (padSync)
  );

  rpscn_sync #(.WIDTH(NUM_CN)) cnSyncer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn (changeNotifyIn),
    .syncOut (cnSync)
  );

  rpscn_lock_if lockBus ();

  assign lockBus.oscWrEn   = oscWrEn;
  assign lockBus.oscWrData = oscWrData;
  assign lockBus.otherWrEn = otherWrEn | mapWrEn | dirWrEn;

  rpscn_unlock unlocker (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .oneWayLockCfg (oneWayLockCfg),
    .lk            (lockBus.keeper)
  );

  // Mapping registers and their shadow copies.
  logic [4:0] inMap_reg     [NI];
  logic [4:0] inMap_next    [NI];
  logic [4:0] inShadow_reg  [NI];
  logic [4:0] outMap_reg    [NUM_RPIN];
  logic [4:0] outMap_next   [NUM_RPIN];
  logic [4:0] outShadow_reg [NUM_RPIN];
  logic       mismatch;

  always_comb
  begin
    mismatch = 1'b0;
    for (int i = 0; i < NI; i++)
    begin
      inMap_next[i] = inMap_reg[i];
      if (mapWrEn && !lockBus.lock && !mapWrOutput && mapWrIndex == 5'(i))
        inMap_next[i] = mapWrData;
      mismatch = mismatch | (inMap_reg[i] != inShadow_reg[i]);
    end
    for (int p = 0; p < NUM_RPIN; p++)
    begin
      outMap_next[p] = outMap_reg[p];
      if (mapWrEn && !lockBus.lock && mapWrOutput && mapWrIndex == 5'(p))
        outMap_next[p] = mapWrData;
      mismatch = mismatch | (outMap_reg[p] != outShadow_reg[p]);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NI; i++)
    begin
      inMap_reg[i]    <= reset ? rpscn_pkg::SEL_GROUND : inMap_next[i];
      inShadow_reg[i] <= reset ? rpscn_pkg::SEL_GROUND : inMap_next[i];
    end
    for (int p = 0; p < NUM_RPIN; p++)
    begin
      outMap_reg[p]    <= reset ? rpscn_pkg::SEL_NULL : outMap_next[p];
      outShadow_reg[p] <= reset ? rpscn_pkg::SEL_NULL : outMap_next[p];
    end
  end

  // Peripheral input selection.
  logic [NI-1:0] periphIn_next;
  logic [NI-1:0] periphIn_reg;

  always_comb
  begin
    for (int i = 0; i < NI; i++)
    begin
      periphIn_next[i] = 1'b0;
      if (inMap_reg[i] < 5'(NUM_RPIN))
        periphIn_next[i] = padSync[inMap_reg[i][3:0]];
    end
  end

  // Pin output selection, direction, reads and converter feed.
  logic [NUM_RPIN-1:0] padOut_reg;
  logic [NUM_RPIN-1:0] padOut_next;
  logic [NUM_RPIN-1:0] padOutEn_reg;
  logic [NUM_RPIN-1:0] padOutEn_next;
  logic [NUM_RPIN-1:0] dir_reg;
  logic [NUM_RPIN-1:0] dir_next;
  logic [NUM_RPIN-1:0] portRead_reg;
  logic [NUM_RPIN-1:0] portRead_next;
  logic [NUM_RPIN-1:0] conv_reg;
  logic [NUM_RPIN-1:0] conv_next;
  logic [4:0]          mapRd_reg;
  logic [4:0]          mapRd_next;

  always_comb
  begin
    dir_next = dirWrEn ? dirWrData : dir_reg;
    for (int p = 0; p < NUM_RPIN; p++)
    begin
      padOutEn_next[p] = 1'b1;
      case (outMap_reg[p])
        rpscn_pkg::SEL_NULL:
        begin
          padOut_next[p]   = portLatch[p];
          padOutEn_next[p] = dir_reg[p] != rpscn_pkg::DIR_INPUT;
        end
        rpscn_pkg::OUT_UART_TX:  padOut_next[p] = uartTransmitOut;
        rpscn_pkg::OUT_UART_RTS: padOut_next[p] = uartRtsOut;
        rpscn_pkg::OUT_SPI_DATA: padOut_next[p] = spiDataOut;
        rpscn_pkg::OUT_SPI_CLK:  padOut_next[p] = spiClockOut;
        rpscn_pkg::OUT_SPI_SEL:  padOut_next[p] = spiSelectOut;
        rpscn_pkg::OUT_CMP_ONE:  padOut_next[p] = compareOutOne;
        rpscn_pkg::OUT_CMP_TWO:  padOut_next[p] = compareOutTwo;
        default:
        begin
          padOut_next[p]   = 1'b0;
          padOutEn_next[p] = 1'b0;
        end
      endcase
      portRead_next[p] = analogPinConfig[p] ? 1'b0 : padSync[p];
      conv_next[p]     = (dir_reg[p] == rpscn_pkg::DIR_INPUT) ? padSync[p] : padOut_reg[p];
    end
    mapRd_next = rpscn_pkg::SEL_NULL;
    if (mapRdOutput && mapRdIndex < 5'(NUM_RPIN))
      mapRd_next = outMap_reg[mapRdIndex[3:0]];
    else if (!mapRdOutput && mapRdIndex < 5'(NI))
      mapRd_next = inMap_reg[mapRdIndex[3:0]];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      padOut_reg   <= '0;
      padOutEn_reg <= '0;
      dir_reg      <= '1;
      portRead_reg <= '0;
      conv_reg     <= '0;
      periphIn_reg <= '0;
      mapRd_reg    <= rpscn_pkg::SEL_NULL;
    end
    else
    begin
      padOut_reg   <= padOut_next;
      padOutEn_reg <= padOutEn_next;
      dir_reg      <= dir_next;
      portRead_reg <= portRead_next;
      conv_reg     <= conv_next;
      periphIn_reg <= periphIn_next;
      mapRd_reg    <= mapRd_next;
    end
  end

  // Change notification and pull-ups.
  logic [NUM_CN-1:0] cnPrev_reg;
  logic [NUM_CN-1:0] cnEnable;
  logic [NUM_CN-1:0] pullup_reg;
  logic [NUM_CN-1:0] pullup_next;
  logic              cnReq_reg;
  logic              cnReq_next;
  logic [2:0]        cnSettle_reg;
  logic [2:0]        cnSettle_next;
  logic              mismatch_reg;

  always_comb
  begin
    cnEnable    = {notifyEnableHigh, notifyEnableLow};
    pullup_next = {pullupEnableHigh, pullupEnableLow};
    // Changes are ignored until the synchronisers and the previous sample hold real levels after reset.
    cnSettle_next = {cnSettle_reg[1:0], 1'b1};
    cnReq_next    = cnSettle_reg[2] & (|((cnSync ^ cnPrev_reg) & cnEnable));
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnPrev_reg   <= '0;
      pullup_reg   <= '0;
      cnReq_reg    <= 1'b0;
      cnSettle_reg <= '0;
      mismatch_reg <= 1'b0;
    end
    else
    begin
      cnPrev_reg   <= cnSync;
      pullup_reg   <= pullup_next;
      cnReq_reg    <= cnReq_next;
      cnSettle_reg <= cnSettle_next;
      mismatch_reg <= mismatch;
    end
  end

  assign padOut          = padOut_reg;
  assign padOutEn        = padOutEn_reg;
  assign pinDirection    = dir_reg;
  assign portRead        = portRead_reg;
  assign converterIn     = conv_reg;
  assign pullupOn        = pullup_reg;
  assign changeNotifyReq = cnReq_reg;
  assign mapRdData       = mapRd_reg;
  assign mapLock         = lockBus.lock;
  assign mismatchReset   = mismatch_reg;
  assign peripheralIn    = periphIn_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  locked_write_a: assert property (
    mapWrEn && lockBus.lock && mapWrOutput && mapWrIndex == 5'h00 |=> $stable(outMap_reg[0]))
    else $error("Locked map write changed a register.");

  null_output_a: assert property (
    outMap_reg[0] == rpscn_pkg::SEL_NULL |=> padOut[0] == $past(portLatch[0]))
    else $error("Null selection did not pass the port latch.");

  uart_route_a: assert property (
    outMap_reg[8] == rpscn_pkg::OUT_UART_TX |=> padOut[8] == $past(uartTransmitOut) && padOutEn[8])
    else $error("UART transmit not routed.");

  spi_clock_a: assert property (
    outMap_reg[11] == rpscn_pkg::OUT_SPI_CLK |=> padOut[11] == $past(spiClockOut))
    else $error("SPI clock not routed.");

  compare_route_a: assert property (
    outMap_reg[14] == rpscn_pkg::OUT_CMP_TWO |=> padOut[14] == $past(compareOutTwo))
    else $error("Compare two not routed.");

  analog_read_a: assert property (
    analogPinConfig[4] |=> !portRead[4])
    else $error("Analog pin read as one.");

  ground_input_a: assert property (
    inMap_reg[rpscn_pkg::IDX_UART_RECEIVE] == rpscn_pkg::SEL_GROUND
    |=> !peripheralIn[rpscn_pkg::IDX_UART_RECEIVE])
    else $error("Grounded input not low.");

  notify_edge_a: assert property (
    $changed(cnSync[3]) && notifyEnableLow[3] && cnSettle_reg[2] |=> changeNotifyReq)
    else $error("Enabled change missed.");

  mismatch_flag_a: assert property (
    inMap_reg[0] != inShadow_reg[0] |=> mismatchReset)
    else $error("Shadow mismatch not reported.");
endmodule

/* sim/rpscn_far_model.sv */
`timescale 1ns/1ps
module rpscn_far_model (
  input  wire logic [15:0] padOut,
  input  wire logic [15:0] padOutEn,
  input  wire logic [15:0] extDrive,
  output logic      [15:0] padIn
);
  // A pin shows the device level while the device drives it, else the external source.
  assign padIn = (padOut & padOutEn) | (extDrive & ~padOutEn);
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [4:0] code;
    logic [6:0] mask;
    logic       en;
  } rpscn_row_t;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] padIn, padOut, padOutEn, pinDirection, portRead, converterIn;
  logic [15:0] portLatch = 16'h0000, extDrive = 16'h0000, analogPinConfig = 16'h0000;
  logic [15:0] dirWrData = 16'h0000, notifyEnableLow = 16'h0000, pullupEnableLow = 16'h0000;
  logic [20:0] changeNotifyIn = 21'h000000;
  logic [20:0] pullupOn;
  logic [4:0]  notifyEnableHigh = 5'h00, pullupEnableHigh = 5'h00;
  logic [4:0]  mapWrIndex = 5'h00, mapWrData = 5'h00, mapRdIndex = 5'h00, mapRdData;
  logic [7:0]  oscWrData = 8'h00;
  logic [6:0]  pv = 7'h00;
  logic [13:0] peripheralIn;
  logic        dirWrEn = 1'b0, mapWrEn = 1'b0, mapWrOutput = 1'b0, mapRdOutput = 1'b0;
  logic        oscWrEn = 1'b0, otherWrEn = 1'b0, oneWayLockCfg = 1'b0;
  logic        changeNotifyReq, mapLock, mismatchReset;
  logic [15:0] ev;
  int          err_total = 0, total_checks = 0, p, i, v, cnt;
  rpscn_row_t  rows [9] = '{'{5'h00, 7'h00, 1'b1}, '{rpscn_pkg::OUT_UART_TX, 7'h01, 1'b1},
    '{rpscn_pkg::OUT_UART_RTS, 7'h02, 1'b1}, '{rpscn_pkg::OUT_SPI_DATA, 7'h04, 1'b1},
    '{rpscn_pkg::OUT_SPI_CLK, 7'h08, 1'b1}, '{rpscn_pkg::OUT_SPI_SEL, 7'h10, 1'b1},
    '{rpscn_pkg::OUT_CMP_ONE, 7'h20, 1'b1}, '{rpscn_pkg::OUT_CMP_TWO, 7'h40, 1'b1}, '{5'h01, 7'h00, 1'b0}};

  always #12.5 sys_clk = ~sys_clk;

  rpscn_far_model far (.padOut(padOut), .padOutEn(padOutEn), .extDrive(extDrive), .padIn(padIn));

  rpscn_top uut (
    .sys_clk(sys_clk), .reset(reset), .padIn(padIn), .padOut(padOut), .padOutEn(padOutEn),
    .portLatch(portLatch), .dirWrEn(dirWrEn), .dirWrData(dirWrData), .pinDirection(pinDirection),
    .analogPinConfig(analogPinConfig), .portRead(portRead), .converterIn(converterIn),
    .changeNotifyIn(changeNotifyIn), .notifyEnableLow(notifyEnableLow), .notifyEnableHigh(notifyEnableHigh),
    .pullupEnableLow(pullupEnableLow), .pullupEnableHigh(pullupEnableHigh), .pullupOn(pullupOn),
    .changeNotifyReq(changeNotifyReq), .mapWrEn(mapWrEn), .mapWrOutput(mapWrOutput),
    .mapWrIndex(mapWrIndex), .mapWrData(mapWrData), .mapRdOutput(mapRdOutput), .mapRdIndex(mapRdIndex),
    .mapRdData(mapRdData), .oscWrEn(oscWrEn), .oscWrData(oscWrData), .otherWrEn(otherWrEn),
    .oneWayLockCfg(oneWayLockCfg), .mapLock(mapLock), .mismatchReset(mismatchReset),
    .uartTransmitOut(pv[0]), .uartRtsOut(pv[1]), .spiDataOut(pv[2]), .spiClockOut(pv[3]),
    .spiSelectOut(pv[4]), .compareOutOne(pv[5]), .compareOutTwo(pv[6]), .peripheralIn(peripheralIn)
  );

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic endTest(input string name);
    chk(mismatchReset, 0);
    $display("Test %s finished", name);
  endtask

  task automatic doReset(input logic w);
    oneWayLockCfg = w;
    reset = 1'b1;
    step(20);
    reset = 1'b0;
    step(1);
  endtask

  task automatic dirWr(input logic [15:0] d);
    dirWrData = d;
    dirWrEn = 1'b1;
    step(1);
    dirWrEn = 1'b0;
    step(1);
  endtask

  task automatic mapWr(input logic o, input logic [4:0] idx, input logic [4:0] d);
    mapWrOutput = o;
    mapWrIndex = idx;
    mapWrData = d;
    mapWrEn = 1'b1;
    step(1);
    mapWrEn = 1'b0;
    step(1);
  endtask

  task automatic mapRd(input logic o, input logic [4:0] idx, input logic [4:0] e);
    mapRdOutput = o;
    mapRdIndex = idx;
    step(1);
    chk(mapRdData, e);
  endtask

  task automatic oscWr(input logic [7:0] d);
    oscWrData = d;
    oscWrEn = 1'b1;
    step(1);
    oscWrEn = 1'b0;
    step(1);
  endtask

  task automatic keySeq(input logic [7:0] d);
    oscWrEn = 1'b1;
    oscWrData = rpscn_pkg::UNLOCK_KEY_A;
    step(1);
    oscWrData = rpscn_pkg::UNLOCK_KEY_B;
    step(1);
    oscWrData = d;
    step(1);
    oscWrEn = 1'b0;
    step(1);
  endtask

  task automatic cnToggle(input int idx, input int exp);
    changeNotifyIn[idx] = ~changeNotifyIn[idx];
    cnt = 0;
    repeat (6)
    begin
      step(1);
      if (changeNotifyReq === 1'b1) cnt++;
    end
    chk(cnt, exp);
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(5000 * 25);
    err_total++;
    give_verdict;
  end

  initial
  begin
    doReset(1'b0);
    chk(pinDirection, 16'hFFFF);
    chk({mapLock, padOutEn, peripheralIn}, 0);
    mapRd(1'b0, 5'h0D, rpscn_pkg::SEL_GROUND);
    mapRd(1'b1, 5'h0F, rpscn_pkg::SEL_NULL);
    endTest("reset");
    dirWr(16'h0000);
    for (int r = 0; r < 9; r++)
    begin
      p = r + 7;
      mapWr(1'b1, p[4:0], rows[r].code);
      for (v = 0; v < 2; v++)
      begin
        pv = v[0] ? rows[r].mask : ~rows[r].mask;
        portLatch = {16{(rows[r].code == 5'h00) ? v[0] : ~v[0]}};
        step(2);
        chk(padOut[p], rows[r].en & v[0]);
        chk(padOutEn[p], rows[r].en);
      end
    end
    endTest("output map");
    doReset(1'b0);
    for (i = 0; i < rpscn_pkg::NUM_PIN_IN; i++) mapWr(1'b0, i[4:0], 5'(15 - i));
    mapRd(1'b0, 5'h00, 5'h0F);
    for (v = 0; v < 2; v++)
    begin
      extDrive = v[0] ? 16'h5A3C : 16'hA5C3;
      step(4);
      for (i = 0; i < 14; i++) ev[i] = extDrive[15 - i];
      chk(peripheralIn, ev[13:0]);
    end
    extDrive = 16'hFFFF;
    mapWr(1'b0, 5'h00, rpscn_pkg::SEL_GROUND);
    mapWr(1'b0, 5'h01, 5'h10);
    step(4);
    chk(peripheralIn[1:0], 2'h0);
    endTest("input map");
    doReset(1'b0);
    extDrive = 16'hA5C3;
    analogPinConfig = 16'h00FF;
    step(4);
    chk(portRead, 16'hA500);
    chk(converterIn, 16'hA5C3);
    portLatch = 16'h3C3C;
    dirWr(16'h0000);
    step(3);
    chk(pinDirection, 16'h0000);
    chk(converterIn, 16'h3C3C);
    endTest("analog");
    notifyEnableLow = 16'h0008;
    notifyEnableHigh = 5'h10;
    pullupEnableLow = 16'h8001;
    pullupEnableHigh = 5'h11;
    step(2);
    chk(pullupOn, 21'h118001);
    cnToggle(3, 1);
    cnToggle(5, 0);
    cnToggle(20, 1);
    endTest("change notify");
    keySeq(8'h40);
    chk(mapLock, 1);
    mapWr(1'b1, 5'h00, rpscn_pkg::OUT_UART_TX);
    mapRd(1'b1, 5'h00, rpscn_pkg::SEL_NULL);
    step(10);
    chk(mapLock, 1);
    keySeq(8'h00);
    chk(mapLock, 0);
    oscWr(rpscn_pkg::UNLOCK_KEY_A);
    otherWrEn = 1'b1;
    step(1);
    otherWrEn = 1'b0;
    step(1);
    oscWr(rpscn_pkg::UNLOCK_KEY_B);
    oscWr(8'h40);
    chk(mapLock, 0);
    oscWr(8'h40);
    chk(mapLock, 0);
    endTest("lock sessions");
    doReset(1'b1);
    cnt = 0;
    repeat (4)
    begin
      step(1);
      if (changeNotifyReq === 1'b1) cnt++;
    end
    chk(cnt, 0);
    keySeq(8'h40);
    chk(mapLock, 1);
    keySeq(8'h00);
    chk(mapLock, 1);
    endTest("one way");
    give_verdict;
  end
endmodule
